// file: rtl/line_acq_consts.vh
// constants for the line scan acquisition control block
// assumes one clock domain and a plain register port
`ifndef LINE_ACQ_CONSTS_VH
`define LINE_ACQ_CONSTS_VH
`define ADDR_CTRL 4'h0
`define ADDR_CMD 4'h1
`define ADDR_XOFF 4'h2
`define ADDR_WIDTH 4'h3
`define ADDR_HEIGHT 4'h4
`define ADDR_HMAX 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_FRAMES 4'h7
`define ADDR_XLIM 4'h8
`define CTRL_MODE_BIT 0
`define CMD_ARM_BIT 0
`define CMD_HALT_BIT 1
`define MODE_ONESHOT 1'b0
`define MODE_CONT 1'b1
`define HEIGHT_ABS_MAX 12'hfff
`define HEIGHT_MIN_CEIL 12'h200
`define RST_XOFF 16'h0000
`define RST_WIDTH 16'h0800
`define RST_HEIGHT 12'h064
`define SETUP_TIME_NS 1000
`define CLK_PERIOD_NS 25
`define SETUP_CYCLES ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: rtl/line_acq_ctrl.v
// acquisition control for a line scan camera: geometry, arm/halt, framing
// assumes line data arrives framed by line_start/line_end pulses, one clock
// Summary of operation
// - lines per frame never above 4095
// - clamp lines per frame to feasible ceiling
// - ceiling at least 512, readable by software
// - one-shot: geometry waits for frame end or halt
// - continuous: geometry waits for halt
// - halt while idle disarms at once
// - halt mid-line lets line finish
// - halt mid-frame sends partial frame, disarms
// - capture policy is one-shot or continuous
// - one-shot captures one frame, then halts itself
// - continuous stays armed until halt
// - continuous captures a frame per trigger
// - one-shot runs setup before each frame
// - frame complete when line count reached
// - two frame descriptor slots, fill while sending
// - line uses pixels from offset for width
`timescale 1ns/1ps
`include "line_acq_consts.vh"
module line_acq_ctrl #(
    parameter SENSOR_PIXELS = 16'd2048,
    parameter HEIGHT_CEIL = 12'hfff
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [15:0] link_ceiling,
    input wire frame_trig,
    input wire line_start,
    input wire line_end,
    input wire [15:0] pix_index,
    input wire pix_valid,
    output wire pix_take,
    output reg [15:0] pix_first,
    output reg [15:0] pix_count,
    output reg capturing,
    output reg armed,
    output wire fb_valid,
    input wire fb_ready,
    output wire [12:0] fb_lines,
    output wire fb_partial
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SETUP = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_LINES = 2'd3;

    reg mode_r;
    reg [15:0] xoff_sh_r, width_sh_r;
    reg [11:0] height_sh_r, height_r;
    reg pend_r;
    reg [1:0] st_r;
    reg in_line_r, halt_pend_r;
    reg [11:0] lines_r;
    reg [7:0] setup_r;
    reg [15:0] frames_r;
    // two-entry frame descriptor buffer
    reg [12:0] q_data_r [0:1];
    reg q_part_r [0:1];
    reg q_wp_r, q_rp_r;
    reg [1:0] q_cnt_r;
    reg push;
    reg push_part;
    wire q_full = (q_cnt_r == 2'd2);
    wire pop = fb_valid & fb_ready;

    // feasible ceiling: link's limit capped at HEIGHT_CEIL and the absolute max, raised to at least HEIGHT_MIN_CEIL
    wire [11:0] link_lim = (link_ceiling > {4'h0, HEIGHT_CEIL}) ?
        HEIGHT_CEIL : link_ceiling[11:0];
    wire [11:0] ceil_raw = (link_lim < `HEIGHT_MIN_CEIL) ?
        `HEIGHT_MIN_CEIL : link_lim;
    wire [11:0] ceil_eff = (ceil_raw > `HEIGHT_ABS_MAX) ?
        `HEIGHT_ABS_MAX : ceil_raw;
    wire [11:0] hreq = (reg_wdata[15:12] != 4'h0) ?
        `HEIGHT_ABS_MAX : reg_wdata[11:0];

    wire wr_cmd = reg_wr & (reg_addr == `ADDR_CMD);
    wire arm_cmd = wr_cmd & reg_wdata[`CMD_ARM_BIT];
    wire halt_cmd = wr_cmd & reg_wdata[`CMD_HALT_BIT];
    wire in_frame = (st_r == ST_LINES) & (lines_r != 12'h000);
    wire frame_done = line_end & in_line_r & (st_r == ST_LINES) &
        (lines_r + 12'h001 >= height_r);

    assign fb_valid = (q_cnt_r != 2'd0);
    assign fb_lines = q_data_r[q_rp_r];
    assign fb_partial = q_part_r[q_rp_r];
    // pixels inside the window only, while capturing and inside a line
    assign pix_take = pix_valid & capturing & in_line_r &
        (pix_index >= pix_first) &
        (pix_index - pix_first < pix_count);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: reg_rdata <= {15'h0000, mode_r};
                `ADDR_XOFF: reg_rdata <= xoff_sh_r;
                `ADDR_WIDTH: reg_rdata <= width_sh_r;
                `ADDR_HEIGHT: reg_rdata <= {4'h0, height_sh_r};
                `ADDR_HMAX: reg_rdata <= {4'h0, ceil_eff};
                `ADDR_STATUS: reg_rdata <= {11'h000, pend_r, q_cnt_r,
                    capturing, armed};
                `ADDR_FRAMES: reg_rdata <= frames_r;
                `ADDR_XLIM: reg_rdata <= SENSOR_PIXELS;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // shadow geometry and deferred copy
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_r <= `MODE_ONESHOT;
            xoff_sh_r <= `RST_XOFF;
            width_sh_r <= `RST_WIDTH;
            height_sh_r <= `RST_HEIGHT;
            height_r <= `RST_HEIGHT;
            pix_first <= `RST_XOFF;
            pix_count <= `RST_WIDTH;
            pend_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_CTRL && !armed)
                mode_r <= reg_wdata[`CTRL_MODE_BIT];
            if (reg_wr && reg_addr == `ADDR_XOFF)
                xoff_sh_r <= reg_wdata;
            if (reg_wr && reg_addr == `ADDR_WIDTH)
                width_sh_r <= reg_wdata;
            if (reg_wr && reg_addr == `ADDR_HEIGHT)
                height_sh_r <= (hreq > ceil_eff) ? ceil_eff : hreq;
            else if (height_sh_r > ceil_eff)
                height_sh_r <= ceil_eff;
            if (reg_wr && (reg_addr == `ADDR_XOFF ||
                reg_addr == `ADDR_WIDTH || reg_addr == `ADDR_HEIGHT))
                pend_r <= 1'b1;
            else if (!armed) begin
                // copy only while not acquiring: frame end or halt
                // ends arming in one-shot, halt only in continuous
                pix_first <= xoff_sh_r;
                pix_count <= width_sh_r;
                height_r <= (height_sh_r == 12'h000) ? 12'h001 :
                    height_sh_r;
                pend_r <= 1'b0;
            end
        end
    end

    always @* begin
        push = 1'b0;
        push_part = 1'b0;
        if (frame_done) begin
            push = 1'b1;
        end else if (halt_pend_r && st_r == ST_LINES && !in_line_r &&
            lines_r != 12'h000) begin
            push = 1'b1;
            push_part = 1'b1;
        end else if (halt_pend_r && st_r == ST_LINES && line_end &&
            in_line_r) begin
            push = 1'b1;
            push_part = 1'b1;
        end
    end

    // arm/halt sequencer and line counting
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            armed <= 1'b0;
            capturing <= 1'b0;
            in_line_r <= 1'b0;
            halt_pend_r <= 1'b0;
            lines_r <= 12'h000;
            setup_r <= 8'h00;
            frames_r <= 16'h0000;
        end else begin
            if (push)
                frames_r <= frames_r + 16'h0001;
            case (st_r)
                ST_IDLE: begin
                    if (arm_cmd && !halt_cmd) begin
                        armed <= 1'b1;
                        setup_r <= 8'h00;
                        st_r <= (mode_r == `MODE_ONESHOT) ? ST_SETUP :
                            ST_WAIT;
                    end
                end
                ST_SETUP: begin
                    // one-shot pays a setup pass per frame
                    if (halt_cmd) begin
                        armed <= 1'b0;
                        st_r <= ST_IDLE;
                    end else if (setup_r == `SETUP_CYCLES - 1) begin
                        st_r <= ST_WAIT;
                    end else begin
                        setup_r <= setup_r + 8'h01;
                    end
                end
                ST_WAIT: begin
                    if (halt_cmd) begin
                        armed <= 1'b0;
                        st_r <= ST_IDLE;
                    end else if (frame_trig && !q_full) begin
                        lines_r <= 12'h000;
                        capturing <= 1'b1;
                        st_r <= ST_LINES;
                    end
                end
                ST_LINES: begin
                    if (halt_cmd)
                        halt_pend_r <= 1'b1;
                    if (line_start && !in_line_r && !halt_pend_r &&
                        !halt_cmd)
                        in_line_r <= 1'b1;
                    if (line_end && in_line_r) begin
                        in_line_r <= 1'b0;
                        lines_r <= lines_r + 12'h001;
                    end
                    if (push || (halt_pend_r && !in_line_r)) begin
                        capturing <= 1'b0;
                        in_line_r <= 1'b0;
                        halt_pend_r <= 1'b0;
                        lines_r <= 12'h000;
                        // a halt landing on the closing edge must not
                        // be lost, or continuous mode stays armed
                        if (push_part || halt_pend_r || halt_cmd ||
                            mode_r == `MODE_ONESHOT) begin
                            armed <= 1'b0;
                            st_r <= ST_IDLE;
                        end else begin
                            st_r <= ST_WAIT;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // frame descriptor buffer toward transmit path
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            q_wp_r <= 1'b0;
            q_rp_r <= 1'b0;
            q_cnt_r <= 2'd0;
            q_data_r[0] <= 13'h0000;
            q_data_r[1] <= 13'h0000;
            q_part_r[0] <= 1'b0;
            q_part_r[1] <= 1'b0;
        end else begin
            // a slot is reserved at frame start, so push never overflows
            if (push) begin
                q_data_r[q_wp_r] <= {1'b0, lines_r} +
                    {12'h000, line_end & in_line_r};
                q_part_r[q_wp_r] <= push_part;
                q_wp_r <= ~q_wp_r;
            end
            if (pop)
                q_rp_r <= ~q_rp_r;
            if (push && !pop)
                q_cnt_r <= q_cnt_r + 2'd1;
            else if (pop && !push)
                q_cnt_r <= q_cnt_r - 2'd1;
        end
    end
endmodule

// file: test/line_acq_props.sv
// port-level checks for the acquisition control block
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
module line_acq_props (
    input wire clk_sys,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [15:0] pix_index,
    input wire pix_valid,
    input wire pix_take,
    input wire [15:0] pix_first,
    input wire [15:0] pix_count,
    input wire capturing,
    input wire armed,
    input wire fb_valid,
    input wire fb_ready,
    input wire [12:0] fb_lines
);
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
// mode mirror; design ignores mode writes while armed
reg mode_r;
always @(posedge clk_sys)
    if (sys_rst)
        mode_r <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0 && !armed)
        mode_r <= reg_wdata[0];
sequence s_halt;
    reg_wr && reg_addr == 4'h1 && reg_wdata[1];
endsequence
sequence s_frame_end;
    capturing ##1 !capturing;
endsequence
a_lines_capped: assert property (fb_valid |-> fb_lines <= 13'h0fff)
    else $error("frame longer than limit");
a_armed_first: assert property (capturing |-> armed)
    else $error("capture while not armed");
a_idle_halt: assert property (!capturing ##0 s_halt |=> !armed)
    else $error("idle halt did not disarm");
a_take_window: assert property (pix_take |-> pix_valid &&
    pix_index >= pix_first &&
    {1'b0, pix_index} < {1'b0, pix_first} + {1'b0, pix_count})
    else $error("pixel taken outside window");
a_geom_frozen: assert property (armed && $past(armed) |->
    $stable(pix_count) && $stable(pix_first))
    else $error("geometry changed while armed");
a_desc_hold: assert property (fb_valid && !fb_ready |=>
    fb_valid && $stable(fb_lines))
    else $error("descriptor lost under stall");
a_ceil_range: assert property (reg_rd && reg_addr == 4'h5 |=>
    reg_rdata >= 16'h0200 && reg_rdata <= 16'h0fff)
    else $error("ceiling out of range");
a_oneshot_stop: assert property (!mode_r ##0 s_frame_end |->
    ##[0:2] !armed)
    else $error("one-shot stayed armed");
endmodule
bind line_acq_ctrl line_acq_props i_props (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_index(pix_index), .pix_valid(pix_valid), .pix_take(pix_take),
    .pix_first(pix_first), .pix_count(pix_count),
    .capturing(capturing), .armed(armed), .fb_valid(fb_valid),
    .fb_ready(fb_ready), .fb_lines(fb_lines));

// file: test/fb_sink.sv
// transmit-path stand-in: pops frame descriptors
// assumes pop on valid and ready; stall models a slow link
`timescale 1ns/1ps
module fb_sink (
    input wire clk_sys,
    input wire sys_rst,
    input wire stall,
    input wire fb_valid,
    input wire [12:0] fb_lines,
    input wire fb_partial,
    output wire fb_ready,
    output reg [12:0] last_lines,
    output reg last_partial,
    output reg [7:0] n_pop
);
assign fb_ready = !stall;
always @(posedge clk_sys)
    if (sys_rst) begin
        n_pop <= 8'h00;
    end else if (fb_valid && fb_ready) begin
        last_lines <= fb_lines;
        last_partial <= fb_partial;
        n_pop <= n_pop + 8'h01;
    end
endmodule

// file: test/tb_top.sv
// self-checking bench for the acquisition control block
// assumes default sensor size and ceiling parameters
`timescale 1ns/1ps
`include "line_acq_consts.vh"
module tb_top;
reg clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
reg frame_trig = 1'b0, line_start = 1'b0, line_end = 1'b0;
reg pix_valid = 1'b0, stall = 1'b0;
reg [3:0] reg_addr = 4'h0;
reg [15:0] reg_wdata = 16'h0000, link_ceiling = 16'hffff;
reg [15:0] pix_index = 16'h0000;
wire [15:0] reg_rdata, pix_first, pix_count;
wire [12:0] fb_lines, last_lines;
wire [7:0] n_pop;
wire pix_take, capturing, armed, fb_valid, fb_ready, fb_partial;
wire last_partial;
integer bad_count = 0, n_compared = 0, takes = 0, k = 0;
always #12.5 clk_sys = !clk_sys;
line_acq_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_ceiling(link_ceiling),
    .frame_trig(frame_trig), .line_start(line_start), .line_end(line_end),
    .pix_index(pix_index), .pix_valid(pix_valid), .pix_take(pix_take),
    .pix_first(pix_first), .pix_count(pix_count), .capturing(capturing),
    .armed(armed), .fb_valid(fb_valid), .fb_ready(fb_ready),
    .fb_lines(fb_lines), .fb_partial(fb_partial));
fb_sink i_sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .stall(stall),
    .fb_valid(fb_valid), .fb_lines(fb_lines), .fb_partial(fb_partial),
    .fb_ready(fb_ready), .last_lines(last_lines),
    .last_partial(last_partial), .n_pop(n_pop));
task close_out;
    $display("compared=%0d failed=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask
task chk(input [15:0] g, input [15:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
// strobe, then one idle edge so back-to-back calls never retoggle
task wr(input [3:0] a, input [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
endtask
task rd(input [3:0] a, input [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
    @(posedge clk_sys);
endtask
task start;
    frame_trig <= 1'b1;
    k = 0;
    while (capturing !== 1'b1 && k < 200) begin
        @(posedge clk_sys);
        k = k + 1;
    end
    frame_trig <= 1'b0;
endtask
// twelve pixels per line; optional halt before the line closes
task line(input h);
    line_start <= 1'b1;
    @(posedge clk_sys);
    line_start <= 1'b0;
    pix_valid <= 1'b1;
    for (k = 0; k < 12; k = k + 1) begin
        pix_index <= k[15:0];
        @(negedge clk_sys);
        if (pix_take === 1'b1) takes = takes + 1;
        @(posedge clk_sys);
    end
    pix_valid <= 1'b0;
    if (h) begin
        wr(4'h1, 16'h0002);
        chk({15'h0, armed}, 16'h0001);
    end
    line_end <= 1'b1;
    @(posedge clk_sys);
    line_end <= 1'b0;
    @(posedge clk_sys);
endtask
task t_limits;
    chk(pix_count, 16'h0800);
    rd(4'hf, 16'h0000);
    rd(4'h8, 16'h0800);
    link_ceiling <= 16'h0100;
    rd(4'h5, 16'h0200);
    link_ceiling <= 16'hffff;
    wr(4'h4, 16'h2000);
    rd(4'h4, 16'h0fff);
    link_ceiling <= 16'h0300;
    wr(4'h2, 16'h0003);
    rd(4'h4, 16'h0300);
    link_ceiling <= 16'hffff;
    wr(4'h4, 16'h0003);
endtask
task t_oneshot;
    wr(4'h3, 16'h0005);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0001);
    start;
    chk({15'h0, k >= `SETUP_CYCLES - 2}, 16'h0001);
    wr(4'h3, 16'h0007);
    chk(pix_count, 16'h0005);
    takes = 0;
    repeat (3) line(1'b0);
    // sink and geometry copy settle on the pop edge, one edge after the push
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(takes, 16'h000f);
    chk(last_lines, 16'h0003);
    chk({last_partial, armed}, 16'h0000);
    chk(pix_count, 16'h0007);
    frame_trig <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({15'h0, capturing}, 16'h0000);
    frame_trig <= 1'b0;
endtask
task t_cont;
    stall <= 1'b1;
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    wr(4'h1, 16'h0001);
    repeat (2) begin
        start;
        repeat (3) line(1'b0);
        wr(4'h3, 16'h0006);
    end
    chk({fb_valid, armed}, 16'h0003);
    chk(pix_count, 16'h0007);
    frame_trig <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({15'h0, capturing}, 16'h0000);
    frame_trig <= 1'b0;
    stall <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(n_pop, 16'h0003);
    start;
    line(1'b0);
    line(1'b1);
    repeat (3) @(posedge clk_sys);
    chk({last_partial, last_lines}, 16'h2002);
    chk({15'h0, armed}, 16'h0000);
    chk(pix_count, 16'h0006);
    rd(4'h7, 16'h0004);
endtask
task t_idle_halt;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0001);
    wr(4'h1, 16'h0002);
    chk({15'h0, armed}, 16'h0000);
endtask
initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_limits;
    t_oneshot;
    t_cont;
    t_idle_halt;
    close_out;
end
initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count = bad_count + 1;
    close_out;
end
endmodule
